//--- design/gafp_cfg_if.sv
`timescale 1ns/1ps
interface gafp_cfg_if;
    logic [7:0][2:0] sense_select;
    logic [7:0] level;
    logic [7:0] event_hit;
    modport ctrl (output sense_select, output level, input event_hit);
    modport sense (input sense_select, input level, output event_hit);
endinterface

//--- design/gafp_pkg.sv
// Overview of operation
// - bias bit three connects pin pull-up
// - sense code zero: buffer on, no flag
// - codes one/two/three: any, rising, falling edge
// - code five flags low level; others reserved
// - code four disables input buffer, no events
// - disabled buffer: pin not sampled nor shown
// - alias and main registers share storage
// - alias offsets zero to three, reset zero
// - direction bit n steers pin n
// - output bit n is pin n drive
// - sensed read returns enabled pin levels
// - writing sensed register toggles output bits
// - flag set on sense match, source pins
// - write one clears flag, zero keeps
// - direction one drives, zero is input
// - output pin driven high or low per bit
// - polarity flip inverts input and output
package gafp_pkg;

    localparam int GAFP_PINS = 8;
    localparam int GAFP_ADDR_W = 5;

    // alias window offsets
    localparam logic [4:0] GAFP_ALIAS_DIR = 5'h00;
    localparam logic [4:0] GAFP_ALIAS_OUT = 5'h01;
    localparam logic [4:0] GAFP_ALIAS_IN = 5'h02;
    localparam logic [4:0] GAFP_ALIAS_FLAGS = 5'h03;

    // main window offsets
    localparam logic [4:0] GAFP_MAIN_DIR = 5'h00;
    localparam logic [4:0] GAFP_MAIN_OUT = 5'h04;
    localparam logic [4:0] GAFP_MAIN_IN = 5'h08;
    localparam logic [4:0] GAFP_MAIN_FLAGS = 5'h09;
    localparam logic [4:0] GAFP_MAIN_CTRL_BASE = 5'h10;

    // per-line config field positions
    localparam int GAFP_POLARITY_BIT = 7;
    localparam int GAFP_BIAS_BIT = 3;
    localparam int GAFP_SENSE_MSB = 2;
    localparam logic [7:0] GAFP_CTRL_MASK = 8'h8F;

    localparam logic [7:0] GAFP_RESET_BYTE = 8'h00;

    typedef enum logic [2:0] {
        GAFP_SENSE_OFF_BUFFER_ON = 3'b000,
        GAFP_SENSE_ANY_EDGE = 3'b001,
        GAFP_SENSE_RISING = 3'b010,
        GAFP_SENSE_FALLING = 3'b011,
        GAFP_SENSE_BUFFER_OFF = 3'b100,
        GAFP_SENSE_LOW_LEVEL = 3'b101
    } gafp_sense_type;

    typedef enum logic [2:0] {
        GAFP_REG_NONE = 3'b000,
        GAFP_REG_DIR = 3'b001,
        GAFP_REG_OUT = 3'b010,
        GAFP_REG_IN = 3'b011,
        GAFP_REG_FLAGS = 3'b100,
        GAFP_REG_CTRL = 3'b101
    } gafp_reg_type;

    // both windows decode onto one set of registers
    function automatic gafp_reg_type gafp_decode(input logic alias_sel,
                                                 input logic [4:0] addr);
        gafp_reg_type r;
        r = GAFP_REG_NONE;
        if (alias_sel) begin
            if (addr == GAFP_ALIAS_DIR) r = GAFP_REG_DIR;
            else if (addr == GAFP_ALIAS_OUT) r = GAFP_REG_OUT;
            else if (addr == GAFP_ALIAS_IN) r = GAFP_REG_IN;
            else if (addr == GAFP_ALIAS_FLAGS) r = GAFP_REG_FLAGS;
        end else begin
            if (addr == GAFP_MAIN_DIR) r = GAFP_REG_DIR;
            else if (addr == GAFP_MAIN_OUT) r = GAFP_REG_OUT;
            else if (addr == GAFP_MAIN_IN) r = GAFP_REG_IN;
            else if (addr == GAFP_MAIN_FLAGS) r = GAFP_REG_FLAGS;
            else if (addr[4:3] == GAFP_MAIN_CTRL_BASE[4:3]) r = GAFP_REG_CTRL;
        end
        return r;
    endfunction

    // reserved codes keep the buffer on
    function automatic logic gafp_buffer_on(input logic [2:0] code);
        return code != GAFP_SENSE_BUFFER_OFF;
    endfunction

endpackage

//--- design/gafp_port.sv
`timescale 1ns/1ps
module gafp_port
    import gafp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic io_alias_sel_in,
    input wire logic [4:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire logic [7:0] pin_level_in,
    output logic [7:0] pin_drive_out,
    output logic [7:0] pin_drive_en_out,
    output logic [7:0] pin_bias_on_out,
    output logic port_irq_out
);
    logic [7:0] dir;
    logic [7:0] out_val;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] ctrl [GAFP_PINS];
    logic [7:0] pin_sync;
    logic [7:0] inv_mask;
    logic [7:0] bias_mask;
    logic [7:0] buf_on_mask;
    logic [7:0] sensed;
    logic [7:0] clear_mask;
    logic [7:0] event_hit;
    logic [7:0] next_rdata;
    gafp_reg_type wr_reg;
    gafp_reg_type rd_reg;

    gafp_cfg_if cfg_bus();

    gafp_sync i_gafp_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .async_in(pin_level_in),
        .sync_out(pin_sync)
    );

    gafp_sense i_gafp_sense (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .cfg(cfg_bus)
    );

    // one decoder maps both windows onto the same registers
    assign wr_reg = io_wr_in ? gafp_decode(io_alias_sel_in, io_addr_in)
                             : GAFP_REG_NONE;
    assign rd_reg = io_rd_in ? gafp_decode(io_alias_sel_in, io_addr_in)
                             : GAFP_REG_NONE;

    always_comb begin
        for (int i = 0; i < GAFP_PINS; i++) begin
            inv_mask[i] = ctrl[i][GAFP_POLARITY_BIT];
            bias_mask[i] = ctrl[i][GAFP_BIAS_BIT];
            buf_on_mask[i] = gafp_buffer_on(ctrl[i][GAFP_SENSE_MSB:0]);
            cfg_bus.sense_select[i] = ctrl[i][GAFP_SENSE_MSB:0];
        end
    end

    // input sense follows the polarity flip
    assign cfg_bus.level = pin_sync ^ inv_mask;
    assign event_hit = cfg_bus.event_hit;

    // lines with the buffer off read as zero
    assign sensed = cfg_bus.level & buf_on_mask;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            dir <= GAFP_RESET_BYTE;
        end else if (wr_reg == GAFP_REG_DIR) begin
            dir <= io_wdata_in;
        end
    end

    // output storage; writing the sensed register toggles it
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            out_val <= GAFP_RESET_BYTE;
        end else if (wr_reg == GAFP_REG_OUT) begin
            out_val <= io_wdata_in;
        end else if (wr_reg == GAFP_REG_IN) begin
            out_val <= out_val ^ io_wdata_in;
        end
    end

    // per-line config; reserved bits are never stored
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < GAFP_PINS; i++) begin
                ctrl[i] <= GAFP_RESET_BYTE;
            end
        end else if (wr_reg == GAFP_REG_CTRL) begin
            ctrl[io_addr_in[2:0]] <= io_wdata_in & GAFP_CTRL_MASK;
        end
    end

    assign clear_mask = (wr_reg == GAFP_REG_FLAGS) ? io_wdata_in
                                                    : GAFP_RESET_BYTE;
    // a new event outranks a clear in the same cycle
    assign next_flags = (flags & ~clear_mask) | event_hit;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flags <= GAFP_RESET_BYTE;
        end else begin
            flags <= next_flags;
        end
    end

    // request rises with the first flag and drops with the last
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            port_irq_out <= 1'b0;
        end else begin
            port_irq_out <= |next_flags;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        next_rdata = GAFP_RESET_BYTE;
        unique case (rd_reg)
            GAFP_REG_NONE: next_rdata = GAFP_RESET_BYTE;
            GAFP_REG_DIR: next_rdata = dir;
            GAFP_REG_OUT: next_rdata = out_val;
            // sensed value is live, never stored
            GAFP_REG_IN: next_rdata = sensed;
            GAFP_REG_FLAGS: next_rdata = flags;
            GAFP_REG_CTRL: next_rdata = ctrl[io_addr_in[2:0]];
            default: next_rdata = GAFP_RESET_BYTE;
        endcase
    end

    // read data holds until the next read so slow readers can sample
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            io_rdata_out <= GAFP_RESET_BYTE;
        end else if (io_rd_in) begin
            io_rdata_out <= next_rdata;
        end
    end

    // pad stage lags the registers by one cycle to keep pins glitch free
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_drive_out <= GAFP_RESET_BYTE;
            pin_drive_en_out <= GAFP_RESET_BYTE;
            pin_bias_on_out <= GAFP_RESET_BYTE;
        end else begin
            pin_drive_out <= out_val ^ inv_mask;
            pin_drive_en_out <= dir;
            pin_bias_on_out <= bias_mask;
        end
    end

    a_flag_set_wins: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        event_hit[2] && (wr_reg == GAFP_REG_FLAGS) && io_wdata_in[2]
        |=> flags[2])
        else $error("event lost against a same-cycle clear");

    a_flag_w1c: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (wr_reg == GAFP_REG_FLAGS) && io_wdata_in[2] && !event_hit[2]
        |=> !flags[2])
        else $error("write one did not clear flag two");

    a_flag_keep: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        flags[2] && !((wr_reg == GAFP_REG_FLAGS) && io_wdata_in[2])
        |=> flags[2])
        else $error("flag two dropped without a clear");

    a_irq_tracks: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        port_irq_out == (flags != 8'h00))
        else $error("interrupt request disagrees with flags");

    a_in_toggles: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (wr_reg == GAFP_REG_IN)
        |=> out_val == ($past(out_val) ^ $past(io_wdata_in)))
        else $error("sensed-register write did not toggle output");

    a_drive_follows: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        1'b1 |=> pin_drive_out == ($past(out_val) ^ $past(inv_mask)))
        else $error("pin drive does not follow output value");

    a_enable_follows: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (wr_reg == GAFP_REG_DIR)
        |=> ##1 pin_drive_en_out == $past(io_wdata_in, 2))
        else $error("drive enable does not follow direction write");

    a_bias_follows: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        1'b1 |=> pin_bias_on_out == $past(bias_mask))
        else $error("pull-up does not follow bias bits");

    a_buf_off_reads: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (rd_reg == GAFP_REG_IN)
        |=> (io_rdata_out & ~$past(buf_on_mask)) == 8'h00)
        else $error("disabled line shows a level");

    a_alias_shared: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        io_rd_in && io_alias_sel_in && (io_addr_in == GAFP_ALIAS_DIR)
        |=> io_rdata_out == $past(dir))
        else $error("alias read differs from shared direction");
endmodule

//--- design/gafp_sense.sv
`timescale 1ns/1ps
module gafp_sense
    import gafp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    gafp_cfg_if.sense cfg
);
    logic [7:0] level_prev;
    logic [7:0] quiet_mask;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            level_prev <= GAFP_RESET_BYTE;
        end else begin
            level_prev <= cfg.level;
        end
    end

    always_comb begin
        for (int i = 0; i < GAFP_PINS; i++) begin
            quiet_mask[i] = 1'b1;
            unique case (cfg.sense_select[i])
                GAFP_SENSE_ANY_EDGE: begin
                    cfg.event_hit[i] = cfg.level[i] ^ level_prev[i];
                    quiet_mask[i] = 1'b0;
                end
                GAFP_SENSE_RISING: begin
                    cfg.event_hit[i] = cfg.level[i] & ~level_prev[i];
                    quiet_mask[i] = 1'b0;
                end
                GAFP_SENSE_FALLING: begin
                    cfg.event_hit[i] = ~cfg.level[i] & level_prev[i];
                    quiet_mask[i] = 1'b0;
                end
                GAFP_SENSE_LOW_LEVEL: begin
                    cfg.event_hit[i] = ~cfg.level[i];
                    quiet_mask[i] = 1'b0;
                end
                // codes zero and four, reserved codes too
                default: begin
                    cfg.event_hit[i] = 1'b0;
                end
            endcase
        end
    end

    a_quiet_codes: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (quiet_mask & cfg.event_hit) == 8'h00)
        else $error("event on a pin whose sense code is quiet");

    a_rise_event: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (cfg.sense_select[2] == GAFP_SENSE_RISING) && cfg.level[2]
        && !level_prev[2] |-> cfg.event_hit[2])
        else $error("rising edge on pin two not reported");

    a_low_event: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (cfg.sense_select[2] == GAFP_SENSE_LOW_LEVEL) && !cfg.level[2]
        |-> cfg.event_hit[2])
        else $error("low level on pin two not reported");
endmodule

//--- design/gafp_sync.sv
`timescale 1ns/1ps
module gafp_sync
    import gafp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    logic [7:0] stage1;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stage1 <= GAFP_RESET_BYTE;
            sync_out <= GAFP_RESET_BYTE;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

//--- tb/gafp_pads.sv
`timescale 1ns/1ps
module gafp_pads (
    input wire logic core_clk_in,
    input wire logic [7:0] drive_in,
    input wire logic [7:0] drive_en_in,
    input wire logic [7:0] bias_on_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] level_out
);
    logic [7:0] float_pat = 8'h55;
    // an open pin wanders, so a stale value is never mistaken for a level
    always @(posedge core_clk_in) float_pat <= ~float_pat;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drive_en_in[i]) level_out[i] = drive_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (bias_on_in[i]) level_out[i] = 1'b1;
            else level_out[i] = float_pat[i];
        end
    end
endmodule

//--- tb/gpio_fast_alias_port_bench.sv
`timescale 1ns/1ps
module gpio_fast_alias_port_bench
    import gafp_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic sel = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, ext_en = 8'hff, ext_val = 8'h00;
    logic [7:0] rdata, drive, drive_en, bias, level;
    logic irq;
    int error_cnt = 0, n_compared = 0, cycles = 0;

    always #5 core_clk_in = ~core_clk_in;

    gafp_port i_gafp_port (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .io_alias_sel_in(sel), .io_addr_in(addr), .io_wr_in(wr),
        .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata),
        .pin_level_in(level), .pin_drive_out(drive),
        .pin_drive_en_out(drive_en), .pin_bias_on_out(bias),
        .port_irq_out(irq));
    gafp_pads i_gafp_pads (.core_clk_in(core_clk_in), .drive_in(drive),
        .drive_en_in(drive_en), .bias_on_in(bias), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .level_out(level));

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic s, input logic [4:0] a,
                          input logic [7:0] d);
        @(negedge core_clk_in);
        sel = s;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge core_clk_in);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic s, input logic [4:0] a,
                          input string what, input logic [7:0] exp);
        @(negedge core_clk_in);
        sel = s;
        addr = a;
        rd = 1'b1;
        @(negedge core_clk_in);
        rd = 1'b0;
        check(what, rdata, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    task automatic test_reset_values();
        for (int a = 0; a < 4; a++) begin
            rd_reg(1'b1, 5'(a), "alias reset", 8'h00);
        end
        rd_reg(1'b0, GAFP_MAIN_FLAGS, "main flags reset", 8'h00);
        rd_reg(1'b0, 5'h17, "line config reset", 8'h00);
        check("drive enable reset", drive_en, 8'h00);
        check("irq reset", {7'h00, irq}, 8'h00);
    endtask

    task automatic test_shared_storage();
        wr_reg(1'b1, GAFP_ALIAS_DIR, 8'ha5);
        rd_reg(1'b0, GAFP_MAIN_DIR, "main dir via alias", 8'ha5);
        wr_reg(1'b0, GAFP_MAIN_OUT, 8'h3c);
        rd_reg(1'b1, GAFP_ALIAS_OUT, "alias out via main", 8'h3c);
        check("drive enable", drive_en, 8'ha5);
        check("drive value", drive, 8'h3c);
        wr_reg(1'b1, GAFP_ALIAS_IN, 8'h0f);
        rd_reg(1'b1, GAFP_ALIAS_OUT, "alias in toggle", 8'h33);
        wr_reg(1'b0, GAFP_MAIN_IN, 8'hff);
        rd_reg(1'b0, GAFP_MAIN_OUT, "main in toggle", 8'hcc);
        wait_cyc(1);
        check("drive after toggle", drive, 8'hcc);
        wr_reg(1'b1, GAFP_ALIAS_DIR, 8'h00);
        wr_reg(1'b1, GAFP_ALIAS_OUT, 8'h00);
    endtask

    task automatic test_sensed_and_bias();
        ext_val = 8'h5a;
        wait_cyc(4);
        rd_reg(1'b1, GAFP_ALIAS_IN, "sensed pins", 8'h5a);
        wr_reg(1'b0, 5'h11, 8'h04);
        wait_cyc(3);
        rd_reg(1'b1, GAFP_ALIAS_IN, "buffer off pin", 8'h58);
        // pin one toggles while its buffer is off, pin zero on code zero
        ext_val = 8'h59;
        wait_cyc(4);
        rd_reg(1'b1, GAFP_ALIAS_FLAGS, "no flag buffer off", 8'h00);
        wr_reg(1'b0, 5'h11, 8'h00);
        ext_en = 8'hf7;
        wr_reg(1'b0, 5'h13, 8'h08);
        wait_cyc(3);
        check("pull-up on", bias, 8'h08);
        rd_reg(1'b1, GAFP_ALIAS_IN, "pulled pin", 8'h59);
        wr_reg(1'b0, 5'h13, 8'h00);
        wait_cyc(1);
        check("pull-up off", bias, 8'h00);
        ext_en = 8'hff;
        ext_val = 8'h00;
        wr_reg(1'b0, 5'h10, 8'h80);
        wait_cyc(3);
        rd_reg(1'b1, GAFP_ALIAS_IN, "flipped input", 8'h01);
        wr_reg(1'b1, GAFP_ALIAS_DIR, 8'h01);
        wait_cyc(1);
        check("flipped output", drive, 8'h01);
        wr_reg(1'b1, GAFP_ALIAS_DIR, 8'h00);
        wr_reg(1'b0, 5'h10, 8'h00);
        wait_cyc(4);
        wr_reg(1'b1, GAFP_ALIAS_FLAGS, 8'hff);
    endtask

    task automatic test_sense_codes();
        logic [7:0] fall_exp, rise_exp;
        for (int c = 0; c < 6; c++) begin
            fall_exp = (c == 1 || c == 3 || c == 5) ? 8'h04 : 8'h00;
            rise_exp = (c == 1 || c == 2 || c == 5) ? 8'h04 : 8'h00;
            ext_val = 8'h04;
            wr_reg(1'b0, 5'h12, 8'(c));
            wait_cyc(4);
            wr_reg(1'b1, GAFP_ALIAS_FLAGS, 8'hff);
            wait_cyc(2);
            rd_reg(1'b1, GAFP_ALIAS_FLAGS, "flags idle high", 8'h00);
            check("irq idle", {7'h00, irq}, 8'h00);
            ext_val = 8'h00;
            wait_cyc(4);
            rd_reg(1'b1, GAFP_ALIAS_FLAGS, "flags fall", fall_exp);
            check("irq fall", {7'h00, irq}, {7'h00, |fall_exp});
            wr_reg(1'b0, GAFP_MAIN_FLAGS, 8'h00);
            rd_reg(1'b0, GAFP_MAIN_FLAGS, "zero write", fall_exp);
            wr_reg(1'b1, GAFP_ALIAS_FLAGS, 8'h04);
            wait_cyc(2);
            rd_reg(1'b1, GAFP_ALIAS_FLAGS, "after clear",
                   (c == 5) ? 8'h04 : 8'h00);
            ext_val = 8'h04;
            wait_cyc(4);
            rd_reg(1'b1, GAFP_ALIAS_FLAGS, "flags rise", rise_exp);
            check("irq rise", {7'h00, irq}, {7'h00, |rise_exp});
        end
        wr_reg(1'b1, GAFP_ALIAS_FLAGS, 8'hff);
        rd_reg(1'b0, 5'h0a, "unmapped read", 8'h00);
    endtask

    task automatic test_mid_reset();
        // output value first so each line drives its 8'h96 bit as soon as it is enabled
        wr_reg(1'b1, GAFP_ALIAS_OUT, 8'h96);
        wr_reg(1'b1, GAFP_ALIAS_DIR, 8'hff);
        wait_cyc(1);
        check("drive before reset", drive, 8'h96);
        check("enable before reset", drive_en, 8'hff);
        reset_in = 1'b1;
        wait_cyc(2);
        reset_in = 1'b0;
        check("enable after reset", drive_en, 8'h00);
        check("drive after reset", drive, 8'h00);
        check("irq after reset", {7'h00, irq}, 8'h00);
        rd_reg(1'b1, GAFP_ALIAS_DIR, "dir after reset", 8'h00);
        rd_reg(1'b1, GAFP_ALIAS_OUT, "out after reset", 8'h00);
    endtask

    initial begin
        wait_cyc(12);
        reset_in = 1'b0;
        test_reset_values();
        test_shared_storage();
        test_sensed_and_bias();
        test_sense_codes();
        test_mid_reset();
        stop_test();
    end
endmodule
